// ===== timer2_map.vh
// How it works
// R1: Clock-out set, timer select clear drives pin
// R2: Clock-out clear leaves pin as input
// R3: Reload bytes capture count or hold reload
// R4: Two byte registers form one 16-bit counter
// R5: Mode chosen from baud, capture, clock-out bits
// R6: Capture mode without trigger enable: plain counter
// R7: Capture mode rollover sets overflow flag
// R8: Trigger falling edge copies count to reload bytes
// R9: Counting continues through a capture
// R10: Capture also sets the external flag
// R11: Both flags share one request line
// R12: Auto-reload rollover sets flag and reloads
// R13: Trigger edge also reloads and sets flag
// R14: Baud rollover reloads, ticks serial shift clocks
// R15: Baud mode trigger edge only sets external flag
// R16: Transmit and receive selects act independently
// R17: Clock-out mode gives 50% duty clock
// R18: Run bit starts the output clock
// R19: Clock-out overflow raises no flag
// R20: Output rate from reload value and prescale
// R21: Six-clock bit zero doubles the rate
// R22: Software halts timer before count access
// R23: Run clear halts and keeps the count
// R24: Counter select picks pin edges or clocks
// R25: Baud select forces auto-reload behaviour
// R26: Only software clears the two flags
// R27: Pins synchronised, falling edges by sampling
// R28: Output toggles on every rollover reload; only clock-out mode toggles it, baud-mode reloads leave it unchanged
`ifndef TIMER2_MAP_VH
`define TIMER2_MAP_VH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define TM_IDX_CONTROL 8'hc8
`define TM_IDX_MODE 8'hc9
`define TM_IDX_RELOAD_LOW 8'hca
`define TM_IDX_RELOAD_HIGH 8'hcb
`define TM_IDX_COUNT_LOW 8'hcc
`define TM_IDX_COUNT_HIGH 8'hcd
`define TM_IDX_CONFIG 8'hce

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define TM_BIT_OVERFLOW 7
`define TM_BIT_EXTERNAL 6
`define TM_BIT_RX_BAUD 5
`define TM_BIT_TX_BAUD 4
`define TM_BIT_EXT_ENABLE 3
`define TM_BIT_RUN 2
`define TM_BIT_COUNTER_SEL 1
`define TM_BIT_CAPTURE_SEL 0

// ----------------------------------------
// Mode and config fields
// ----------------------------------------
`define TM_BIT_CLOCK_OUT_EN 1
`define TM_MODE_MASK 8'h02
`define TM_BIT_SIX_CLOCK 6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TM_RST_BYTE 8'h00
`define TM_RST_CONFIG 8'hff

// ----------------------------------------
// Prescale counts in oscillator clocks
// ----------------------------------------
`define TM_SLOW_DIV_12T 4'hc
`define TM_SLOW_DIV_6T 4'h6
`define TM_FAST_DIV_12T 4'h2
`define TM_FAST_DIV_6T 4'h1

`endif

// ===== timer2_pin_sync.v
`timescale 1ns/1ps
module timer2_pin_sync #(
  parameter WIDTH = 2
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Raw pins and results
  input wire [WIDTH-1:0] pin_i,
  output wire [WIDTH-1:0] level_o,
  output wire [WIDTH-1:0] fall_o
);

  genvar g;

  // ----------------------------------------
  // Two-stage synchroniser plus history stage
  // ----------------------------------------
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_pin
      reg meta;
      reg stable;
      reg prior;
      // Meta stage feeds only the stable stage
      always @(posedge clk_i) begin // [R27]
        if (rst_i) begin
          meta <= 1'b1;
          stable <= 1'b1;
          prior <= 1'b1;
        end else begin
          meta <= pin_i[g];
          stable <= meta;
          prior <= stable;
        end
      end
      assign level_o[g] = stable;
      assign fall_o[g] = prior & ~stable; // [R27]
    end
  endgenerate

endmodule

// ===== timer2_prescaler.v
`timescale 1ns/1ps
`include "timer2_map.vh"
module timer2_prescaler (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Clock scheme select, 0 means six-clock
  input wire six_clock_mode_i,
  // Count enables
  output wire fast_tick_o,
  output wire slow_tick_o
);

  reg [3:0] slow_count;
  reg [3:0] fast_count;
  wire [3:0] slow_last;
  wire [3:0] fast_last;

  // Period select by clock scheme
  assign slow_last = six_clock_mode_i ? `TM_SLOW_DIV_12T - 4'h1 :
                     `TM_SLOW_DIV_6T - 4'h1; // [R21]
  assign fast_last = six_clock_mode_i ? `TM_FAST_DIV_12T - 4'h1 :
                     `TM_FAST_DIV_6T - 4'h1; // [R21]

  // ----------------------------------------
  // Free-running dividers
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      slow_count <= 4'h0;
      fast_count <= 4'h0;
    end else begin
      slow_count <= (slow_count >= slow_last) ? 4'h0 : slow_count + 4'h1;
      fast_count <= (fast_count >= fast_last) ? 4'h0 : fast_count + 4'h1;
    end
  end

  assign slow_tick_o = (slow_count >= slow_last);
  assign fast_tick_o = (fast_count >= fast_last); // [R20]

endmodule

// ===== timer2_core.v
`timescale 1ns/1ps
`include "timer2_map.vh"
module timer2_core (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Avalon-MM slave
  input wire [9:0] address_i,
  input wire read_i,
  input wire write_i,
  input wire [31:0] writedata_i,
  input wire [3:0] byteenable_i,
  output reg [31:0] readdata_o,
  output wire waitrequest_o,
  // Count clock pin, three-signal form
  input wire count_clock_pin_i,
  output reg count_clock_pin_o,
  output reg count_clock_pin_oe_o,
  // External trigger pin
  input wire external_trigger_pin_i,
  // Serial port shift clocks and selects
  output reg transmit_baud_tick_o,
  output reg receive_baud_tick_o,
  output wire transmit_baud_select_o,
  output wire receive_baud_select_o,
  // Shared request line
  output wire timer_request_o
);

  // ----------------------------------------
  // Operating modes
  // ----------------------------------------
  localparam MODE_CAPTURE = 2'b00;
  localparam MODE_RELOAD = 2'b01;
  localparam MODE_BAUD = 2'b10;
  localparam MODE_CLOCK_OUT = 2'b11;

  // Register index hit on a word-aligned byte address
  function reg_hit;
    input [9:0] addr;
    input [7:0] index;
    begin
      reg_hit = (addr[9:2] == index);
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [7:0] control_register;
  reg [7:0] mode_register;
  reg [7:0] config_byte_three;
  reg [7:0] reload_capture_low;
  reg [7:0] reload_capture_high;
  reg [7:0] count_low;
  reg [7:0] count_high;
  reg clock_out_level;
  reg bus_ack;

  reg [7:0] next_control;
  reg [7:0] next_count_low;
  reg [7:0] next_count_high;
  reg [7:0] next_reload_low;
  reg [7:0] next_reload_high;
  reg next_clock_out_level;
  reg [7:0] read_value;
  reg [1:0] mode;
  reg count_tick;

  wire [1:0] pin_fall;
  wire fast_tick;
  wire slow_tick;
  wire count_pin_fall;
  wire trigger_fall;
  wire [15:0] count_value;
  wire [15:0] reload_value;
  wire rollover;
  wire trigger_event;
  wire wr_strobe;
  wire [7:0] wr_byte;

  // Named control bits
  wire overflow_flag = control_register[`TM_BIT_OVERFLOW];
  wire external_flag = control_register[`TM_BIT_EXTERNAL];
  wire receive_baud_select = control_register[`TM_BIT_RX_BAUD];
  wire transmit_baud_select = control_register[`TM_BIT_TX_BAUD];
  wire external_trigger_enable = control_register[`TM_BIT_EXT_ENABLE];
  wire run_control = control_register[`TM_BIT_RUN];
  wire counter_timer_select = control_register[`TM_BIT_COUNTER_SEL];
  wire capture_reload_select = control_register[`TM_BIT_CAPTURE_SEL];
  wire clock_out_enable = mode_register[`TM_BIT_CLOCK_OUT_EN];
  wire six_clock_mode = config_byte_three[`TM_BIT_SIX_CLOCK];

  // ----------------------------------------
  // Pin synchronisers and prescaler
  // ----------------------------------------
  timer2_pin_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i({external_trigger_pin_i, count_clock_pin_i}),
    .level_o(),
    .fall_o(pin_fall)
  );

  assign count_pin_fall = pin_fall[0]; // [R27]
  assign trigger_fall = pin_fall[1]; // [R27]

  timer2_prescaler u_prescaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .six_clock_mode_i(six_clock_mode),
    .fast_tick_o(fast_tick),
    .slow_tick_o(slow_tick)
  );

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  // Baud selects override capture select and clock-out
  always @* begin
    if (receive_baud_select | transmit_baud_select) begin
      mode = MODE_BAUD; // [R5] [R25]
    end else if (capture_reload_select) begin
      mode = MODE_CAPTURE; // [R5]
    end else if (clock_out_enable) begin
      mode = MODE_CLOCK_OUT; // [R5] [R17]
    end else begin
      mode = MODE_RELOAD; // [R5]
    end
  end

  // Count source: pin edges or internal prescaled clocks
  always @* begin
    if (!run_control) begin
      count_tick = 1'b0; // [R23]
    end else if (counter_timer_select) begin
      count_tick = count_pin_fall; // [R24]
    end else begin
      case (mode)
        MODE_BAUD: count_tick = fast_tick; // [R20]
        MODE_CLOCK_OUT: count_tick = fast_tick; // [R20] [R21]
        MODE_CAPTURE: count_tick = slow_tick; // [R24]
        MODE_RELOAD: count_tick = slow_tick; // [R24]
        default: count_tick = slow_tick;
      endcase
    end
  end

  assign count_value = {count_high, count_low}; // [R4]
  assign reload_value = {reload_capture_high, reload_capture_low};
  assign rollover = count_tick & (count_value == 16'hffff);
  assign trigger_event = trigger_fall & external_trigger_enable;

  // ----------------------------------------
  // Bus write strobe
  // ----------------------------------------
  // Write lands at the edge where waitrequest is low
  assign wr_strobe = write_i & bus_ack & byteenable_i[0];
  assign wr_byte = writedata_i[7:0];

  // ----------------------------------------
  // Counter, reload registers and flags
  // ----------------------------------------
  always @* begin
    next_control = control_register;
    next_count_low = count_low;
    next_count_high = count_high;
    next_reload_low = reload_capture_low;
    next_reload_high = reload_capture_high;
    next_clock_out_level = clock_out_level;
    // Software writes, flags included
    if (wr_strobe && reg_hit(address_i, `TM_IDX_CONTROL)) begin
      next_control = wr_byte;
    end
    if (wr_strobe && reg_hit(address_i, `TM_IDX_RELOAD_LOW)) begin
      next_reload_low = wr_byte;
    end
    if (wr_strobe && reg_hit(address_i, `TM_IDX_RELOAD_HIGH)) begin
      next_reload_high = wr_byte;
    end
    // Counting; capture never stalls it
    if (count_tick) begin
      {next_count_high, next_count_low} = count_value + 16'h0001; // [R9]
    end
    case (mode)
      MODE_CAPTURE: begin
        if (rollover) begin
          next_control[`TM_BIT_OVERFLOW] = 1'b1; // [R7]
        end
        // No trigger enable means plain counter
        if (trigger_event) begin // [R6]
          next_reload_low = count_low; // [R3] [R8]
          next_reload_high = count_high; // [R3] [R8]
          next_control[`TM_BIT_EXTERNAL] = 1'b1; // [R10]
        end
      end
      MODE_RELOAD: begin
        if (rollover || trigger_event) begin
          next_count_low = reload_capture_low; // [R3] [R12] [R13]
          next_count_high = reload_capture_high; // [R12] [R13]
        end
        if (rollover) begin
          next_control[`TM_BIT_OVERFLOW] = 1'b1; // [R12]
        end
        if (trigger_event) begin
          next_control[`TM_BIT_EXTERNAL] = 1'b1; // [R13]
        end
      end
      MODE_BAUD: begin
        // Rollover feeds the serial port, not the flag
        if (rollover) begin
          next_count_low = reload_capture_low; // [R14]
          next_count_high = reload_capture_high; // [R14]
        end
        if (trigger_event) begin
          next_control[`TM_BIT_EXTERNAL] = 1'b1; // [R15]
        end
      end
      MODE_CLOCK_OUT: begin
        // Toggle per reload gives a 50% duty square wave
        if (rollover) begin
          next_count_low = reload_capture_low; // [R20]
          next_count_high = reload_capture_high; // [R20]
          next_clock_out_level = ~clock_out_level; // [R17] [R28]
        end
        if (trigger_event) begin
          next_control[`TM_BIT_EXTERNAL] = 1'b1; // [R19]
        end
      end
      default: begin
        next_control = control_register;
      end
    endcase
    // Byte writes to the counter override counting
    if (wr_strobe && reg_hit(address_i, `TM_IDX_COUNT_LOW)) begin
      next_count_low = wr_byte; // [R4]
    end
    if (wr_strobe && reg_hit(address_i, `TM_IDX_COUNT_HIGH)) begin
      next_count_high = wr_byte; // [R4]
    end
  end

  // Register update; hardware flag set beats software clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      control_register <= `TM_RST_BYTE;
      reload_capture_low <= `TM_RST_BYTE;
      reload_capture_high <= `TM_RST_BYTE;
      count_low <= `TM_RST_BYTE;
      count_high <= `TM_RST_BYTE;
      clock_out_level <= 1'b0;
    end else begin
      control_register <= next_control; // [R26]
      reload_capture_low <= next_reload_low;
      reload_capture_high <= next_reload_high;
      count_low <= next_count_low;
      count_high <= next_count_high;
      clock_out_level <= next_clock_out_level; // [R18]
    end
  end

  // Mode and config registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      mode_register <= `TM_RST_BYTE;
      config_byte_three <= `TM_RST_CONFIG;
    end else begin
      if (wr_strobe && reg_hit(address_i, `TM_IDX_MODE)) begin
        mode_register <= wr_byte & `TM_MODE_MASK;
      end
      if (wr_strobe && reg_hit(address_i, `TM_IDX_CONFIG)) begin
        config_byte_three <= wr_byte; // [R21]
      end
    end
  end

  // ----------------------------------------
  // Count clock pin drive
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      count_clock_pin_o <= 1'b0;
      count_clock_pin_oe_o <= 1'b0;
    end else begin
      count_clock_pin_o <= clock_out_level; // [R17]
      // Drive only with clock-out on and timer select clear
      count_clock_pin_oe_o <= clock_out_enable &
                              ~counter_timer_select; // [R1] [R2]
    end
  end

  // ----------------------------------------
  // Serial shift clocks
  // ----------------------------------------
  // Each direction follows its own select
  always @(posedge clk_i) begin
    if (rst_i) begin
      transmit_baud_tick_o <= 1'b0;
      receive_baud_tick_o <= 1'b0;
    end else begin
      transmit_baud_tick_o <= rollover & (mode == MODE_BAUD) &
                              transmit_baud_select; // [R14] [R16]
      receive_baud_tick_o <= rollover & (mode == MODE_BAUD) &
                             receive_baud_select; // [R14] [R16]
    end
  end

  assign transmit_baud_select_o = transmit_baud_select; // [R16]
  assign receive_baud_select_o = receive_baud_select; // [R16]

  // Both flags share one request
  assign timer_request_o = overflow_flag | external_flag; // [R11]

  // ----------------------------------------
  // Avalon read path and wait states
  // ----------------------------------------
  // Read mux; unmapped indices and reserved mode bits read zero
  always @* begin
    read_value = 8'h00;
    if (reg_hit(address_i, `TM_IDX_CONTROL)) begin
      read_value = control_register;
    end else if (reg_hit(address_i, `TM_IDX_MODE)) begin
      read_value = mode_register;
    end else if (reg_hit(address_i, `TM_IDX_RELOAD_LOW)) begin
      read_value = reload_capture_low;
    end else if (reg_hit(address_i, `TM_IDX_RELOAD_HIGH)) begin
      read_value = reload_capture_high;
    end else if (reg_hit(address_i, `TM_IDX_COUNT_LOW)) begin
      read_value = count_low; // [R4]
    end else if (reg_hit(address_i, `TM_IDX_COUNT_HIGH)) begin
      read_value = count_high; // [R4]
    end else if (reg_hit(address_i, `TM_IDX_CONFIG)) begin
      read_value = config_byte_three;
    end
  end

  // One wait state per access; data latched before release
  always @(posedge clk_i) begin
    if (rst_i) begin
      bus_ack <= 1'b0;
      readdata_o <= 32'h00000000;
    end else begin
      bus_ack <= (read_i | write_i) & ~bus_ack;
      if (read_i && !bus_ack) begin
        readdata_o <= {24'h000000, read_value};
      end
    end
  end

  assign waitrequest_o = (read_i | write_i) & ~bus_ack;

endmodule

// ===== timer2_chk.sv
`timescale 1ns/1ps
`include "timer2_map.vh"
module timer2_chk (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Register bus
  input wire [9:0] address_i,
  input wire read_i,
  input wire write_i,
  input wire [31:0] writedata_i,
  input wire [3:0] byteenable_i,
  input wire [31:0] readdata_o,
  input wire waitrequest_o,
  // Pin and serial side
  input wire count_clock_pin_o,
  input wire count_clock_pin_oe_o,
  input wire transmit_baud_tick_o,
  input wire receive_baud_tick_o,
  input wire transmit_baud_select_o,
  input wire receive_baud_select_o,
  input wire timer_request_o
);
  // ------------------------------
  // Shadows of software writes
  // ------------------------------
  reg [7:0] ctl_sh;
  reg [7:0] mode_sh;
  wire [7:0] idx = address_i[9:2];
  wire req = read_i || write_i;
  wire wr_done = write_i && !waitrequest_o && byteenable_i[0];
  wire ctl_wr = wr_done && idx == `TM_IDX_CONTROL;
  wire run_sh = ctl_sh[2];
  wire co_mode = mode_sh[1] && ctl_sh[5:4] == 2'h0 && !ctl_sh[0];

  // Track control and mode bytes as software wrote them
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctl_sh <= 8'h00;
      mode_sh <= 8'h00;
    end else if (ctl_wr) begin
      ctl_sh <= writedata_i[7:0];
    end else if (wr_done && idx == `TM_IDX_MODE) begin
      mode_sh <= writedata_i[7:0];
    end
  end

  // ------------------------------
  // Properties
  // ------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_pin_drive: assert property (!$past(wr_done) |->
    count_clock_pin_oe_o == (mode_sh[1] && !ctl_sh[1]))
    else $error("clock pin drive does not follow enables");
  a_one_wait: assert property (req && waitrequest_o |=>
    !waitrequest_o) else $error("more than one wait state");
  a_wait_first: assert property (req && !$past(req) |->
    waitrequest_o) else $error("new request answered at once");
  a_read_byte: assert property (read_i && !waitrequest_o |->
    readdata_o[31:8] == 24'h000000) else $error("read upper bits set");
  a_flag_clear: assert property ($fell(timer_request_o) |->
    $past(ctl_wr)) else $error("flag cleared without software");
  a_baud_quiet: assert property ($rose(timer_request_o) &&
    (transmit_baud_select_o || receive_baud_select_o) && !ctl_sh[3]
    |-> $past(wr_done)) else $error("request raised in baud mode");
  a_clkout_quiet: assert property ($rose(timer_request_o) &&
    co_mode && !ctl_sh[3] |-> $past(wr_done))
    else $error("request raised in clock-out mode");
  a_tx_tick_sel: assert property (transmit_baud_tick_o |->
    $past(transmit_baud_select_o) || $past(transmit_baud_select_o, 2))
    else $error("transmit tick without its select");
  a_rx_tick_sel: assert property (receive_baud_tick_o |->
    $past(receive_baud_select_o) || $past(receive_baud_select_o, 2))
    else $error("receive tick without its select");
  a_run_halt: assert property (count_clock_pin_oe_o && !run_sh &&
    !$past(run_sh) && !$past(run_sh, 2) |-> $stable(count_clock_pin_o))
    else $error("clock output moves while halted");

  c_request: cover property ($rose(timer_request_o));
  c_tx_tick: cover property (transmit_baud_tick_o);
  c_clock_out: cover property (count_clock_pin_oe_o &&
    $changed(count_clock_pin_o));
endmodule

bind timer2_core timer2_chk u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
  .write_i(write_i), .writedata_i(writedata_i),
  .byteenable_i(byteenable_i), .readdata_o(readdata_o),
  .waitrequest_o(waitrequest_o), .count_clock_pin_o(count_clock_pin_o),
  .count_clock_pin_oe_o(count_clock_pin_oe_o),
  .transmit_baud_tick_o(transmit_baud_tick_o),
  .receive_baud_tick_o(receive_baud_tick_o),
  .transmit_baud_select_o(transmit_baud_select_o),
  .receive_baud_select_o(receive_baud_select_o),
  .timer_request_o(timer_request_o)
);

// ===== timer2_far_side.sv
`timescale 1ns/1ps
module timer2_far_side (
  // Clock
  input wire clk_i,
  // Levels the bench wants on the pins
  input wire trig_level_i,
  input wire count_level_i,
  // Device side
  input wire pin_out_i,
  input wire pin_oe_i,
  input wire tx_tick_i,
  input wire rx_tick_i,
  // Pin wires and observations
  output wire trigger_pin_o,
  output wire count_pin_o,
  output int tx_ticks_o,
  output int rx_ticks_o,
  output int half_len_o
);
  int run_len = 0;
  logic last_pin = 1'h1;

  // The device wins the count pin while it drives it
  assign count_pin_o = pin_oe_i ? pin_out_i : count_level_i;
  assign trigger_pin_o = trig_level_i;

  // Count one serial bit per rollover pulse; time the clock halves
  always @(posedge clk_i) begin
    if (tx_tick_i)
      tx_ticks_o <= tx_ticks_o + 1;
    if (rx_tick_i)
      rx_ticks_o <= rx_ticks_o + 1;
    last_pin <= count_pin_o;
    if (count_pin_o != last_pin) begin
      half_len_o <= run_len;
      run_len <= 1;
    end else begin
      run_len <= run_len + 1;
    end
  end
endmodule

// ===== test_timer2_capture_reload_clockout.sv
`timescale 1ns/1ps
`include "timer2_map.vh"
module test_timer2_capture_reload_clockout;
  // ------------------------------
  // Bench signals
  // ------------------------------
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic [9:0] address_i = 10'h000;
  logic read_i = 1'h0;
  logic write_i = 1'h0;
  logic [31:0] writedata_i = 32'h00000000;
  logic [3:0] byteenable_i = 4'hf;
  logic trig_level = 1'h1;
  logic count_level = 1'h1;
  logic [7:0] rd;
  wire [31:0] readdata_o;
  wire waitrequest_o, pin_out, pin_oe, trig_pin, count_pin;
  wire tx_tick, rx_tick, request;
  int tx_ticks, rx_ticks, half_len;
  int n_mismatch = 0;
  int comparisons = 0;

  // Device and far side
  timer2_core DUT (
    .clk_i(clk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i),
    .byteenable_i(byteenable_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .count_clock_pin_i(count_pin),
    .count_clock_pin_o(pin_out), .count_clock_pin_oe_o(pin_oe),
    .external_trigger_pin_i(trig_pin), .transmit_baud_tick_o(tx_tick),
    .receive_baud_tick_o(rx_tick), .transmit_baud_select_o(),
    .receive_baud_select_o(), .timer_request_o(request)
  );
  timer2_far_side far (
    .clk_i(clk_i), .trig_level_i(trig_level), .count_level_i(count_level),
    .pin_out_i(pin_out), .pin_oe_i(pin_oe), .tx_tick_i(tx_tick),
    .rx_tick_i(rx_tick), .trigger_pin_o(trig_pin), .count_pin_o(count_pin),
    .tx_ticks_o(tx_ticks), .rx_ticks_o(rx_ticks), .half_len_o(half_len)
  );

  // 50 MHz clock
  initial begin
    forever #10 clk_i = ~clk_i;
  end

  // ------------------------------
  // Shared tasks
  // ------------------------------
  task end_sim;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One register access, held until waitrequest is seen low
  task bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    int k;
    @(posedge clk_i);
    address_i <= {idx, 2'h0};
    writedata_i <= {24'h000000, d};
    read_i <= ~wr;
    write_i <= wr;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (waitrequest_o && k < 20);
    rd = readdata_o[7:0];
    read_i <= 1'h0;
    write_i <= 1'h0;
    if (waitrequest_o) begin
      n_mismatch++;
      end_sim;
    end
  endtask

  task rdc(input logic [7:0] idx, input logic [7:0] exp, input string what);
    bus(1'h0, idx, 8'h00);
    chk(what, exp, rd);
  endtask

  // One pin pulse, low and high long enough for the synchroniser
  task pulse(input logic trig);
    @(posedge clk_i);
    if (trig)
      trig_level <= 1'h0;
    else
      count_level <= 1'h0;
    repeat (3) @(posedge clk_i);
    trig_level <= 1'h1;
    count_level <= 1'h1;
    repeat (7) @(posedge clk_i);
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  task t_regs;
    logic [7:0] ix [8] = '{8'hc8, 8'hc9, 8'hca, 8'hcb, 8'hcc, 8'hcd,
      8'hce, 8'hd0};
    logic [7:0] ex [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'hff, 8'h00};
    for (int i = 0; i < 8; i++) begin
      rdc(ix[i], ex[i], $sformatf("reset %h", ix[i]));
    end
    bus(1'h1, `TM_IDX_MODE, 8'hff);
    rdc(`TM_IDX_MODE, 8'h02, "mode bits");
    bus(1'h1, `TM_IDX_MODE, 8'h00);
    bus(1'h1, `TM_IDX_COUNT_HIGH, 8'ha5);
    byteenable_i <= 4'h0;
    bus(1'h1, `TM_IDX_COUNT_HIGH, 8'h11);
    byteenable_i <= 4'hf;
    bus(1'h1, 8'hd0, 8'h77);
    rdc(`TM_IDX_COUNT_HIGH, 8'ha5, "count high rw");
    rdc(8'hd0, 8'h00, "unmapped");
  endtask

  task t_capture;
    bus(1'h1, `TM_IDX_COUNT_LOW, 8'hfe);
    bus(1'h1, `TM_IDX_COUNT_HIGH, 8'hff);
    bus(1'h1, `TM_IDX_CONTROL, 8'h0f);
    repeat (3) pulse(1'h0);
    pulse(1'h1);
    pulse(1'h0);
    rdc(`TM_IDX_RELOAD_LOW, 8'h01, "capture low");
    rdc(`TM_IDX_RELOAD_HIGH, 8'h00, "capture high");
    rdc(`TM_IDX_COUNT_LOW, 8'h02, "count on");
    rdc(`TM_IDX_CONTROL, 8'hcf, "capture flags");
    chk("request", 32'h1, request);
    bus(1'h1, `TM_IDX_CONTROL, 8'h07);
    pulse(1'h1);
    rdc(`TM_IDX_CONTROL, 8'h07, "no capture");
    rdc(`TM_IDX_RELOAD_LOW, 8'h01, "held low");
    chk("request clear", 32'h0, request);
  endtask

  task t_reload;
    bus(1'h1, `TM_IDX_CONTROL, 8'h00);
    bus(1'h1, `TM_IDX_RELOAD_LOW, 8'h34);
    bus(1'h1, `TM_IDX_RELOAD_HIGH, 8'h12);
    bus(1'h1, `TM_IDX_COUNT_LOW, 8'hff);
    bus(1'h1, `TM_IDX_COUNT_HIGH, 8'hff);
    bus(1'h1, `TM_IDX_CONTROL, 8'h0e);
    pulse(1'h0);
    rdc(`TM_IDX_COUNT_LOW, 8'h34, "reload low");
    rdc(`TM_IDX_COUNT_HIGH, 8'h12, "reload high");
    rdc(`TM_IDX_CONTROL, 8'h8e, "reload flag");
    bus(1'h1, `TM_IDX_CONTROL, 8'h0a);
    bus(1'h1, `TM_IDX_COUNT_LOW, 8'h50);
    bus(1'h1, `TM_IDX_CONTROL, 8'h0e);
    pulse(1'h1);
    rdc(`TM_IDX_COUNT_LOW, 8'h34, "trigger reload");
    rdc(`TM_IDX_CONTROL, 8'h4e, "trigger flag");
    bus(1'h1, `TM_IDX_CONTROL, 8'h00);
  endtask

  task t_baud;
    int tx0;
    int rx0;
    bus(1'h1, `TM_IDX_RELOAD_LOW, 8'hfc);
    bus(1'h1, `TM_IDX_RELOAD_HIGH, 8'hff);
    bus(1'h1, `TM_IDX_COUNT_LOW, 8'hff);
    bus(1'h1, `TM_IDX_COUNT_HIGH, 8'hff);
    tx0 = tx_ticks;
    rx0 = rx_ticks;
    bus(1'h1, `TM_IDX_CONTROL, 8'h14);
    repeat (160) @(posedge clk_i);
    rdc(`TM_IDX_CONTROL, 8'h14, "baud no flag");
    bus(1'h1, `TM_IDX_CONTROL, 8'h00);
    chk("tx ticks", 32'h1, (tx_ticks - tx0) inside {[19:22]});
    chk("rx ticks", rx0, rx_ticks);
    bus(1'h1, `TM_IDX_CONTROL, 8'h2c);
    pulse(1'h1);
    rdc(`TM_IDX_CONTROL, 8'h6c, "baud trigger");
    chk("rx used", 32'h1, rx_ticks > rx0);
    bus(1'h1, `TM_IDX_CONTROL, 8'h00);
  endtask

  task t_clockout;
    bus(1'h1, `TM_IDX_RELOAD_LOW, 8'hf0);
    bus(1'h1, `TM_IDX_MODE, 8'h02);
    bus(1'h1, `TM_IDX_CONTROL, 8'h04);
    repeat (100) @(posedge clk_i);
    chk("pin drive", 32'h1, pin_oe);
    chk("half", 2 * (65536 - 32'h0000fff0), half_len);
    chk("no request", 32'h0, request);
    bus(1'h1, `TM_IDX_CONFIG, 8'hbf);
    repeat (60) @(posedge clk_i);
    chk("six clock half", 65536 - 32'h0000fff0, half_len);
    bus(1'h1, `TM_IDX_CONTROL, 8'h00);
    bus(1'h1, `TM_IDX_CONFIG, 8'hff);
    bus(1'h1, `TM_IDX_CONTROL, 8'h06);
    repeat (3) @(posedge clk_i);
    chk("counter select", 32'h0, pin_oe);
    bus(1'h1, `TM_IDX_CONTROL, 8'h04);
    bus(1'h1, `TM_IDX_MODE, 8'h00);
    repeat (3) @(posedge clk_i);
    chk("port pin", 32'h0, pin_oe);
    bus(1'h1, `TM_IDX_CONTROL, 8'h00);
  endtask

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
    t_regs;
    t_capture;
    t_reload;
    t_baud;
    t_clockout;
    end_sim;
  end
endmodule
